// File: shared/hsb_params.svh
// Timing and layout constants for the host system-bus DMA port.
// Assumes inclusion by bare name from shared/.
`ifndef HSB_PARAMS_SVH
`define HSB_PARAMS_SVH
`define HSB_ADDR_W 32
`define HSB_DATA_W 16
`define HSB_LANE_W 8
`define HSB_CLK_HZ 10000000
`define HSB_BUS_CLK_MIN_HZ 2000000
`define HSB_BUS_CLK_MAX_HZ 33000000
`define HSB_BUS_DIV 2
`define HSB_UP_ADDR_HI 31
`define HSB_UP_ADDR_LO 15
`define HSB_LO_ADDR_HI 23
`define HSB_LO_ADDR_LO 7
`endif

// File: shared/hsb_pkg.sv
// Device-end state type, and the odd-parity function shared by both ends of the host system-bus DMA port.
// Assumes hsb_params.svh is on the include path.
`include "hsb_params.svh"
package hsb_pkg;
  typedef enum logic [2:0] {
    HSB_IDLE = 3'b000,
    HSB_REQ = 3'b001,
    HSB_ADDR_HI = 3'b010,
    HSB_ADDR_LO = 3'b011,
    HSB_DATA = 3'b100,
    HSB_DONE = 3'b101
  } hsb_state_t;

  function automatic logic hsb_odd_par(input logic [7:0] b);
    return ~(^b);
  endfunction : hsb_odd_par
endpackage : hsb_pkg

// File: shared/hsb_if.sv
// Interface joining the device end and the host end of the system bus.
// Two-way lanes are resolved here from each end's output enable.
`timescale 1ns/1ps
`default_nettype none
interface hsb_if;
  logic bus_clk_en;
  logic [7:0] up_dev_o, lo_dev_o, up_host_o, lo_host_o;
  logic up_dev_oe, lo_dev_oe, up_host_oe, lo_host_oe;
  logic par_hi_dev, par_lo_dev, par_hi_host, par_lo_host;
  logic addr_latch_pulse;
  logic bus_busy_in;
  logic hold_request_out;
  logic hold_ack;
  logic release_request_in;
  logic style_sel;
  logic ube_dev_o, ube_dev_oe;
  logic read_not_write_line;
  logic xfer_ack;
  wire [7:0] upper_addr_data_lane = up_dev_oe ? up_dev_o : (up_host_oe ? up_host_o : 8'hff);
  wire [7:0] lower_addr_data_lane = lo_dev_oe ? lo_dev_o : (lo_host_oe ? lo_host_o : 8'hff);
  wire upper_lane_parity = up_dev_oe ? par_hi_dev : (up_host_oe ? par_hi_host : 1'b1);
  wire lower_lane_parity = lo_dev_oe ? par_lo_dev : (lo_host_oe ? par_lo_host : 1'b1);
  wire upper_byte_enable_n = ube_dev_oe ? ube_dev_o : 1'b1;
  modport dev (
    input bus_clk_en, upper_addr_data_lane, lower_addr_data_lane, upper_lane_parity,
    lower_lane_parity, bus_busy_in, hold_ack, release_request_in, style_sel, xfer_ack,
    output up_dev_o, lo_dev_o, up_dev_oe, lo_dev_oe, par_hi_dev, par_lo_dev,
    addr_latch_pulse, hold_request_out, ube_dev_o, ube_dev_oe, read_not_write_line
  );
  modport host (
    input upper_addr_data_lane, lower_addr_data_lane, upper_lane_parity, lower_lane_parity,
    addr_latch_pulse, hold_request_out, upper_byte_enable_n, read_not_write_line, up_dev_oe,
    output bus_clk_en, up_host_o, lo_host_o, up_host_oe, lo_host_oe, par_hi_host,
    par_lo_host, bus_busy_in, hold_ack, release_request_in, style_sel, xfer_ack
  );
endinterface : hsb_if
`default_nettype wire

// File: src/hsb_dev.sv
// Device end of the host system-bus DMA port: arbitration and multiplexed cycles.
// Assumes the host end supplies the bus clock enable, grant and acknowledge.
`timescale 1ns/1ps
`default_nettype none
module hsb_dev (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // User request side
  input wire logic start_i,
  input wire logic write_i,
  input wire logic byte_hi_i,
  input wire logic [31:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [7:0] count_i,
  output logic busy_o,
  output logic done_o,
  output logic rvalid_o,
  output logic [15:0] rdata_o,
  output logic par_err_o,
  // Bus side
  hsb_if.dev bus
);
  hsb_pkg::hsb_state_t state, next_state;
  logic busy_s1, busy_s2, rel_s1, rel_s2;
  logic [31:0] addr;
  logic [15:0] wdata;
  logic [7:0] left;
  logic wr, bhi;
  wire tick = bus.bus_clk_en;
  wire grant_ok = bus.hold_ack & busy_s2;
  wire in_dma = (state == hsb_pkg::HSB_ADDR_HI) || (state == hsb_pkg::HSB_ADDR_LO)
    || (state == hsb_pkg::HSB_DATA);
  wire drive_data = (state == hsb_pkg::HSB_DATA) & wr;
  wire [7:0] up_val = (state == hsb_pkg::HSB_ADDR_HI) ? addr[31:24] :
    (state == hsb_pkg::HSB_ADDR_LO) ? addr[15:8] : wdata[15:8];
  wire [7:0] lo_val = (state == hsb_pkg::HSB_ADDR_HI) ? addr[23:16] :
    (state == hsb_pkg::HSB_ADDR_LO) ? addr[7:0] : wdata[7:0];
  wire lane_drive = in_dma & ((state != hsb_pkg::HSB_DATA) | drive_data);
  wire rd_par_bad = (bus.upper_lane_parity != hsb_pkg::hsb_odd_par(bus.upper_addr_data_lane))
    | (bus.lower_lane_parity != hsb_pkg::hsb_odd_par(bus.lower_addr_data_lane));
  wire data_end = tick & (state == hsb_pkg::HSB_DATA) & bus.xfer_ack;
  wire more = (left != 8'h01);

  // Synchronisers for inputs from the host domain
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      rel_s1 <= 1'b1;
      rel_s2 <= 1'b1;
    end else begin
      busy_s1 <= bus.bus_busy_in;
      busy_s2 <= busy_s1;
      rel_s1 <= bus.release_request_in;
      rel_s2 <= rel_s1;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      hsb_pkg::HSB_IDLE: if (start_i) next_state = hsb_pkg::HSB_REQ;
      hsb_pkg::HSB_REQ: if (tick & grant_ok) next_state = hsb_pkg::HSB_ADDR_HI;
      hsb_pkg::HSB_ADDR_HI: if (tick) next_state = hsb_pkg::HSB_ADDR_LO;
      hsb_pkg::HSB_ADDR_LO: if (tick) next_state = hsb_pkg::HSB_DATA;
      hsb_pkg::HSB_DATA: begin
        if (data_end) begin
          if (!more) next_state = hsb_pkg::HSB_DONE;
          else if (!rel_s2) next_state = hsb_pkg::HSB_REQ;
          else next_state = hsb_pkg::HSB_ADDR_HI;
        end
      end
      hsb_pkg::HSB_DONE: next_state = hsb_pkg::HSB_IDLE;
      default: next_state = hsb_pkg::HSB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= hsb_pkg::HSB_IDLE;
      addr <= 32'h0000_0000;
      wdata <= 16'h0000;
      left <= 8'h00;
      wr <= 1'b0;
      bhi <= 1'b0;
    end else begin
      state <= next_state;
      if (state == hsb_pkg::HSB_IDLE && start_i) begin
        addr <= addr_i;
        wdata <= wdata_i;
        left <= (count_i == 8'h00) ? 8'h01 : count_i;
        wr <= write_i;
        bhi <= byte_hi_i;
      end else if (data_end) begin
        addr <= addr + 32'h0000_0002;
        left <= left - 8'h01;
      end
    end
  end

  // Read data, parity error and done registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= 16'h0000;
      par_err_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      rvalid_o <= data_end & ~wr;
      done_o <= (state == hsb_pkg::HSB_DONE);
      if (data_end & ~wr) begin
        rdata_o <= {bus.upper_addr_data_lane, bus.lower_addr_data_lane};
        par_err_o <= rd_par_bad;
      end
    end
  end

  assign busy_o = (state != hsb_pkg::HSB_IDLE);
  assign bus.hold_request_out = (state != hsb_pkg::HSB_IDLE)
    && (state != hsb_pkg::HSB_DONE);
  assign bus.addr_latch_pulse = (state == hsb_pkg::HSB_ADDR_LO);
  assign bus.up_dev_o = up_val;
  assign bus.lo_dev_o = lo_val;
  assign bus.up_dev_oe = lane_drive;
  assign bus.lo_dev_oe = lane_drive;
  assign bus.par_hi_dev = hsb_pkg::hsb_odd_par(up_val);
  assign bus.par_lo_dev = hsb_pkg::hsb_odd_par(lo_val);
  assign bus.ube_dev_oe = in_dma & bus.style_sel;
  assign bus.ube_dev_o = ~bhi;
  assign bus.read_not_write_line = ~bus.style_sel & in_dma ? ~wr : 1'b1;
endmodule : hsb_dev
`default_nettype wire

// File: src/hsb_host.sv
// Host end of the system bus: bus clock enable, grant, memory slave for DMA.
// Assumes the device end follows the multiplexed address/data sequence.
`timescale 1ns/1ps
`default_nettype none
module hsb_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // User control side
  input wire logic other_busy_i,
  input wire logic release_i,
  input wire logic style_sep_i,
  input wire logic [15:0] rd_data_i,
  output logic [31:0] addr_o,
  output logic wr_valid_o,
  output logic [15:0] wr_data_o,
  output logic par_err_o,
  // Bus side
  hsb_if.host bus
);
  logic [1:0] div;
  logic [15:0] hi_addr;
  logic [7:0] up_lat, lo_lat;
  logic seen_hi, grant;
  wire tick = (div == 2'(`HSB_BUS_DIV - 1));
  // Strobe style has no direction line: a read is a data phase the device leaves undriven
  wire dev_reads = bus.style_sel ? ~bus.up_dev_oe : bus.read_not_write_line;
  wire lanes_driven_by_dev = bus.hold_request_out & ~bus.addr_latch_pulse & seen_hi;
  wire par_bad = (bus.upper_lane_parity != hsb_pkg::hsb_odd_par(bus.upper_addr_data_lane))
    | (bus.lower_lane_parity != hsb_pkg::hsb_odd_par(bus.lower_addr_data_lane));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= 2'b00;
      grant <= 1'b0;
      hi_addr <= 16'h0000;
      up_lat <= 8'h00;
      lo_lat <= 8'h00;
      seen_hi <= 1'b0;
      addr_o <= 32'h0000_0000;
      wr_valid_o <= 1'b0;
      wr_data_o <= 16'h0000;
      par_err_o <= 1'b0;
    end else begin
      div <= tick ? 2'b00 : div + 2'b01;
      grant <= bus.hold_request_out;
      wr_valid_o <= 1'b0;
      // Keeps the last tick before the latch pulse, which is the upper address phase
      if (tick & bus.hold_request_out & ~seen_hi & ~bus.addr_latch_pulse & bus.hold_ack) begin
        hi_addr <= {bus.upper_addr_data_lane, bus.lower_addr_data_lane};
      end
      if (bus.addr_latch_pulse) begin
        up_lat <= bus.upper_addr_data_lane;
        lo_lat <= bus.lower_addr_data_lane;
        par_err_o <= par_bad;
        seen_hi <= 1'b1;
      end
      if (tick & seen_hi & bus.xfer_ack) begin
        addr_o <= {hi_addr[15:8], hi_addr[7:0], up_lat, lo_lat};
        wr_valid_o <= ~dev_reads;
        wr_data_o <= {bus.upper_addr_data_lane, bus.lower_addr_data_lane};
        seen_hi <= 1'b0;
      end
      if (~bus.hold_request_out) seen_hi <= 1'b0;
    end
  end

  assign bus.bus_clk_en = tick;
  assign bus.hold_ack = grant;
  assign bus.bus_busy_in = ~other_busy_i;
  assign bus.release_request_in = ~release_i;
  assign bus.style_sel = style_sep_i;
  assign bus.xfer_ack = seen_hi & ~bus.addr_latch_pulse;
  assign bus.up_host_o = rd_data_i[15:8];
  assign bus.lo_host_o = rd_data_i[7:0];
  assign bus.up_host_oe = dev_reads & lanes_driven_by_dev & ~bus.addr_latch_pulse;
  assign bus.lo_host_oe = dev_reads & lanes_driven_by_dev & ~bus.addr_latch_pulse;
  assign bus.par_hi_host = hsb_pkg::hsb_odd_par(rd_data_i[15:8]);
  assign bus.par_lo_host = hsb_pkg::hsb_odd_par(rd_data_i[7:0]);
endmodule : hsb_host
`default_nettype wire

// File: tb/hsb_asserts.sv
// Concurrent checks on the system-bus signals between the device and host ends.
// Assumes plain connection to the hsb_if signals from the testbench top.
`timescale 1ns/1ps
`default_nettype none
module hsb_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Device-driven bus signals, plus the host-driven style select
  input wire logic [7:0] up_dev_o,
  input wire logic [7:0] lo_dev_o,
  input wire logic up_dev_oe,
  input wire logic lo_dev_oe,
  input wire logic par_hi_dev,
  input wire logic par_lo_dev,
  input wire logic addr_latch_pulse,
  input wire logic hold_request_out,
  input wire logic ube_dev_oe,
  input wire logic read_not_write_line,
  input wire logic style_sel
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_par_upper: assert property (up_dev_oe |-> par_hi_dev == ~(^up_dev_o))
    else $error("upper lane parity not odd");
  a_par_lower: assert property (lo_dev_oe |-> par_lo_dev == ~(^lo_dev_o))
    else $error("lower lane parity not odd");
  a_ube_style: assert property (!style_sel |-> !ube_dev_oe)
    else $error("byte enable driven in read/write style");
  a_ube_idle: assert property (!hold_request_out |-> !ube_dev_oe)
    else $error("byte enable driven outside DMA");
  a_rnw_sep: assert property (style_sel && $past(style_sel) |-> read_not_write_line)
    else $error("direction line low in strobe style");
  a_latch_owned: assert property (addr_latch_pulse |-> hold_request_out && up_dev_oe && lo_dev_oe)
    else $error("latch pulse without bus ownership");
  a_latch_len: assert property ($rose(addr_latch_pulse) |=> addr_latch_pulse ##1 !addr_latch_pulse)
    else $error("latch pulse not one bus tick");
  a_upper_first: assert property ($rose(addr_latch_pulse) |-> $past(up_dev_oe) && $past(lo_dev_oe))
    else $error("low address half without upper half before");
endmodule : hsb_asserts
`default_nettype wire

// File: tb/host_system_bus_dma_port_tb_top.sv
// Testbench joining the device and host ends of the system-bus DMA port.
// Assumes shared/ and src/ files compiled first; expectations wait in queues.
`timescale 1ns/1ps
`default_nettype none
module host_system_bus_dma_port_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0, write_i = 1'b0, byte_hi_i = 1'b0, other_busy_i = 1'b0;
  logic release_i = 1'b0, style_sep_i = 1'b1, lat_d = 1'b0;
  logic [31:0] addr_i = '0, addr_o, seed = 32'h0001_2bdd;
  logic [15:0] wdata_i = '0, rd_data_i = '0, rdata_o, wr_data_o;
  logic [7:0] count_i = '0;
  logic busy_o, done_o, rvalid_o, dev_perr, wr_valid_o, host_perr;
  logic [47:0] q_lat[$], q_rd[$], q_wr[$];
  int err_total = 0, cmp_count = 0, lat_n = 0, n0;
  always #50 clk_i = ~clk_i;
  hsb_if bus ();
  hsb_dev hsb_dev_i (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .write_i(write_i),
    .byte_hi_i(byte_hi_i), .addr_i(addr_i), .wdata_i(wdata_i), .count_i(count_i),
    .busy_o(busy_o), .done_o(done_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
    .par_err_o(dev_perr), .bus(bus));
  hsb_host hsb_host_i (.clk_i(clk_i), .rst_i(rst_i), .other_busy_i(other_busy_i),
    .release_i(release_i), .style_sep_i(style_sep_i), .rd_data_i(rd_data_i), .addr_o(addr_o),
    .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o), .par_err_o(host_perr), .bus(bus));
  hsb_asserts hsb_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .up_dev_o(bus.up_dev_o),
    .lo_dev_o(bus.lo_dev_o), .up_dev_oe(bus.up_dev_oe), .lo_dev_oe(bus.lo_dev_oe),
    .par_hi_dev(bus.par_hi_dev), .par_lo_dev(bus.par_lo_dev),
    .addr_latch_pulse(bus.addr_latch_pulse), .hold_request_out(bus.hold_request_out),
    .ube_dev_oe(bus.ube_dev_oe), .read_not_write_line(bus.read_not_write_line),
    .style_sel(bus.style_sel));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic cmp(input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (e !== g) begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task automatic summarize();
    $display("mismatches=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wait_done();
    int i;
    for (i = 0; i < 500 && done_o !== 1'b1; i++) tick(1);
    if (i == 500) begin
      err_total++;
      summarize();
    end
    cmp({46'h0, dev_perr, host_perr}, 48'h0);
  endtask : wait_done
  // Starts one burst and notes every latch, read and write it must produce
  task automatic go(input logic w, input logic [7:0] n, input bit wt);
    logic [31:0] a;
    int k;
    for (k = 0; k < 50 && busy_o !== 1'b0; k++) tick(1);
    if (k == 50) begin
      err_total++;
      summarize();
    end
    write_i = w;
    byte_hi_i = rnd() & 1;
    addr_i = rnd() & ~32'h1;
    wdata_i = rnd();
    rd_data_i = rnd();
    count_i = n;
    for (k = 0; k < ((n == 0) ? 1 : n); k++) begin
      a = addr_i + 2 * k;
      q_lat.push_back({30'h0, style_sep_i ? ~byte_hi_i : 1'b1, style_sep_i | ~w, a[15:0]});
      if (w) q_wr.push_back({a, wdata_i});
      else q_rd.push_back({32'h0, rd_data_i});
    end
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
    if (wt) wait_done();
  endtask : go
  always @(posedge clk_i) begin
    lat_d <= bus.addr_latch_pulse;
    if (bus.addr_latch_pulse && !lat_d) begin
      lat_n++;
      cmp(q_lat.size() ? q_lat.pop_front() : 48'hx, {30'h0, bus.upper_byte_enable_n,
        bus.read_not_write_line, bus.upper_addr_data_lane, bus.lower_addr_data_lane});
    end
    if (wr_valid_o) cmp(q_wr.size() ? q_wr.pop_front() : 48'hx, {addr_o, wr_data_o});
    if (rvalid_o) cmp(q_rd.size() ? q_rd.pop_front() : 48'hx, {32'h0, rdata_o});
  end
  initial begin
    tick(4);
    rst_i = 1'b0;
    for (int s = 0; s < 2; s++) begin
      style_sep_i = s[0];
      tick(2);
      go(1'b1, 8'h0, 1'b1);
      go(1'b1, 8'h1, 1'b1);
      go(1'b0, 8'h3, 1'b1);
    end
    other_busy_i = 1'b1;
    tick(3);
    n0 = lat_n;
    go(1'b0, 8'h2, 1'b0);
    tick(30);
    cmp(48'(n0), 48'(lat_n));
    other_busy_i = 1'b0;
    wait_done();
    release_i = 1'b1;
    go(1'b0, 8'h3, 1'b1);
    go(1'b1, 8'h1, 1'b1);
    release_i = 1'b0;
    repeat (6) begin
      style_sep_i = rnd() & 1;
      tick(2);
      go(1'b0, 8'(rnd() & 3), 1'b1);
    end
    tick(5);
    cmp(48'(q_lat.size() + q_rd.size() + q_wr.size()), 48'h0);
    summarize();
  end
endmodule : host_system_bus_dma_port_tb_top
`default_nettype wire
